// ==== rtl/deadband_defs.vh ====
// Purpose: Shared constants of the dead-band and chopper stage
// Assumes: 32-bit register bus, one aligned word per register
// Notes:   Offsets are byte addresses on the register bus
`ifndef DEADBAND_DEFS_VH
`define DEADBAND_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_DEADBAND_CONTROL 4'h0
`define OFS_RISING_DELAY     4'h4
`define OFS_FALLING_DELAY    4'h8
`define OFS_CHOPPER_CONTROL  4'hC

// ----------------------------------------------------------------
// Field positions and writable masks
// ----------------------------------------------------------------
`define DBC_OUT_MODE_LSB     0
`define DBC_POL_SEL_LSB      2
`define DBC_IN_SEL_LSB       4
`define DBC_MASK             16'h003F
`define DELAY_MASK           16'h03FF
`define PCC_ENABLE_BIT       0
`define PCC_WIDTH_LSB        1
`define PCC_FREQ_LSB         5
`define PCC_DUTY_LSB         8
`define PCC_MASK             16'h07FF

// ----------------------------------------------------------------
// Reset values, timing and bus response codes
// ----------------------------------------------------------------
`define REG_RESET            16'h0000
`define CARRIER_STEPS        8
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// ==== rtl/edge_delay.v ====
// Purpose: Delays one chosen edge of a signal by a programmed count
// Assumes: tb_en is a one-cycle pulse per time-base period
// Notes:   The other edge passes with one clock of latency only
`default_nettype none

module edge_delay #(
    parameter RISING = 1,
    parameter WIDTH  = 10
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             tb_en,
    input  wire [WIDTH-1:0] count,
    input  wire             src,
    output wire             dly
);

    reg  [WIDTH-1:0] cnt;
    reg              held;
    wire             lvl;

    // Work on the edge of interest as if it were a rising edge
    assign lvl = (RISING != 0) ? src : ~src;
    assign dly = (RISING != 0) ? held : ~held;

    // Count time-base periods while the delayed level stands
    always @(posedge clk) begin
        if (!rst_n) begin
            cnt  <= {WIDTH{1'b0}};
            held <= 1'b0;
        end else if (!lvl) begin
            cnt  <= {WIDTH{1'b0}};
            held <= 1'b0;
        end else if (cnt >= count) begin
            held <= 1'b1;
        end else if (tb_en) begin
            cnt  <= cnt + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule

`default_nettype wire

// ==== rtl/deadband_and_chopper_stage.v ====
// Purpose: Dead-band insertion, polarity and carrier chopping of a
//          PWM channel pair, set up over an AXI4-Lite slave
// Assumes: chan_a_in, chan_b_in and tb_en come from logic on clk
// Notes:   Raw-path outputs lag the inputs by one clock through the stage
//
// Functional notes
// - Polarity 00 inverts neither output; reset default.
// - Polarity 01 inverts A, 10 inverts B, 11 inverts both.
// - Output mode upper bit selects A path, lower bit selects B path.
// - Output mode 00 forwards both raw channels to the chopper.
// - In output mode 00 polarity and input select have no effect.
// - Mode 01: A raw, B takes the falling-edge delayed signal.
// - Mode 10: A takes rising-edge delayed signal, B raw.
// - Mode 11: A rising-delayed, B falling-delayed.
// - Input select picks A or B as source for each delay.
// - Rising delay is a 10-bit count, resets zero, upper bits zero.
// - Falling delay is a 10-bit count, resets zero, upper bits zero.
// - Duty code n gives carrier high (n+1)/8; code 111 reserved.
// - Carrier is clock/8 further divided by frequency code plus one.
// - One-shot width is (code+1) times eight clock periods.
// - Chopper enable cleared passes dead-band outputs unchanged.
`include "deadband_defs.vh"
`default_nettype none

module deadband_and_chopper_stage #(
    parameter DELAY_WIDTH = 10
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        tb_en,
    input  wire        chan_a_in,
    input  wire        chan_b_in,
    output reg         chop_a,
    output reg         chop_b
);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    reg  [15:0] deadband_control;
    reg  [15:0] rising_delay_count;
    reg  [15:0] falling_delay_count;
    reg  [15:0] chopper_control;

    reg  [3:0]  wr_addr;
    reg  [31:0] wr_data;
    reg  [3:0]  wr_strb;
    reg         aw_full;
    reg         w_full;
    wire        aw_take;
    wire        w_take;
    wire        wr_go;
    wire        ar_take;
    reg         next_aw_full;
    reg         next_w_full;
    reg         next_bvalid;
    reg         next_rvalid;
    wire [15:0] wr_merge_src;
    reg  [15:0] wr_old;
    wire [15:0] wr_new;
    reg         wr_hit;
    reg  [15:0] rd_val;
    reg         rd_hit;

    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take  = s_axi_wvalid & s_axi_wready;
    assign wr_go   = aw_full & w_full & ~s_axi_bvalid;
    assign ar_take = s_axi_arvalid & s_axi_arready;

    // Handshake bookkeeping; one write and one read in flight at most
    always @* begin
        next_aw_full = (aw_full | aw_take) & ~wr_go;
        next_w_full  = (w_full | w_take) & ~wr_go;
        next_bvalid  = wr_go | (s_axi_bvalid & ~s_axi_bready);
        next_rvalid  = ar_take | (s_axi_rvalid & ~s_axi_rready);
    end

    // Old value of the addressed register, for byte-lane merging
    always @* begin
        wr_hit = 1'b1;
        case (wr_addr)
            `OFS_DEADBAND_CONTROL: wr_old = deadband_control;
            `OFS_RISING_DELAY:     wr_old = rising_delay_count;
            `OFS_FALLING_DELAY:    wr_old = falling_delay_count;
            `OFS_CHOPPER_CONTROL:  wr_old = chopper_control;
            default: begin
                wr_old = `REG_RESET;
                wr_hit = 1'b0;
            end
        endcase
    end

    // Only the two low byte lanes hold register bits
    assign wr_merge_src = wr_data[15:0];
    assign wr_new = {wr_strb[1] ? wr_merge_src[15:8] : wr_old[15:8],
                     wr_strb[0] ? wr_merge_src[7:0]  : wr_old[7:0]};

    // Write channel: address and data in either order, then response
    always @(posedge clk) begin
        if (!rst_n) begin
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            wr_addr       <= 4'h0;
            wr_data       <= 32'h00000000;
            wr_strb       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end else begin
            if (aw_take)
                wr_addr <= s_axi_awaddr;
            if (w_take) begin
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (wr_go)
                s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            aw_full       <= next_aw_full;
            w_full        <= next_w_full;
            s_axi_bvalid  <= next_bvalid;
            s_axi_awready <= ~next_aw_full & ~next_bvalid;
            s_axi_wready  <= ~next_w_full & ~next_bvalid;
        end
    end

    // Register update; reserved bits are masked off on every write
    // masked writes, zero reset
    always @(posedge clk) begin
        if (!rst_n) begin
            deadband_control    <= `REG_RESET;
            rising_delay_count  <= `REG_RESET;
            falling_delay_count <= `REG_RESET;
            chopper_control     <= `REG_RESET;
        end else if (wr_go) begin
            case (wr_addr)
                `OFS_DEADBAND_CONTROL:
                    deadband_control <= wr_new & `DBC_MASK;
                `OFS_RISING_DELAY:
                    rising_delay_count <= wr_new & `DELAY_MASK;
                `OFS_FALLING_DELAY:
                    falling_delay_count <= wr_new & `DELAY_MASK;
                `OFS_CHOPPER_CONTROL:
                    chopper_control <= wr_new & `PCC_MASK;
                default: begin
                end
            endcase
        end
    end

    // Read decode; unmapped addresses read zero with an error
    always @* begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `OFS_DEADBAND_CONTROL: rd_val = deadband_control;
            `OFS_RISING_DELAY:     rd_val = rising_delay_count;
            `OFS_FALLING_DELAY:    rd_val = falling_delay_count;
            `OFS_CHOPPER_CONTROL:  rd_val = chopper_control;
            default: begin
                rd_val = `REG_RESET;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read channel: data answers one clock after the address is taken
    always @(posedge clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            if (ar_take) begin
                s_axi_rdata <= {16'h0000, rd_val};
                s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
            s_axi_rvalid  <= next_rvalid;
            s_axi_arready <= ~next_rvalid;
        end
    end

    // ------------------------------------------------------------
    // Dead-band generator
    // ------------------------------------------------------------
    wire [1:0] out_mode;
    wire [1:0] polarity_select;
    wire [1:0] in_select;
    wire       rise_src;
    wire       fall_src;
    wire       rise_dly;
    wire       fall_dly;
    wire       path_a;
    wire       path_b;
    wire       db_a;
    wire       db_b;

    assign out_mode        = deadband_control[`DBC_OUT_MODE_LSB +: 2];
    assign polarity_select = deadband_control[`DBC_POL_SEL_LSB +: 2];
    assign in_select       = deadband_control[`DBC_IN_SEL_LSB +: 2];

    assign rise_src = in_select[0] ? chan_b_in : chan_a_in;
    assign fall_src = in_select[1] ? chan_b_in : chan_a_in;

    edge_delay #(
        .RISING (1),
        .WIDTH  (DELAY_WIDTH)
    ) rise_delay (
        .clk   (clk),
        .rst_n (rst_n),
        .tb_en (tb_en),
        .count (rising_delay_count[DELAY_WIDTH-1:0]),
        .src   (rise_src),
        .dly   (rise_dly)
    );

    edge_delay #(
        .RISING (0),
        .WIDTH  (DELAY_WIDTH)
    ) fall_delay (
        .clk   (clk),
        .rst_n (rst_n),
        .tb_en (tb_en),
        .count (falling_delay_count[DELAY_WIDTH-1:0]),
        .src   (fall_src),
        .dly   (fall_dly)
    );

    // polarity codes follow from the two bits
    assign path_a = rise_dly ^ polarity_select[0];
    assign path_b = fall_dly ^ polarity_select[1];

    // Raw inputs are not registered, so the delayed paths gain a
    // clock against the bypass; a delayed edge lands count+1 clocks late.
    // output switches
    assign db_a = out_mode[1] ? path_a : chan_a_in;
    assign db_b = out_mode[0] ? path_b : chan_b_in;

    // ------------------------------------------------------------
    // Chopper carrier
    // ------------------------------------------------------------
    wire       chopper_enable;
    wire [3:0] one_shot_width;
    wire [2:0] chopper_frequency;
    wire [2:0] chopper_duty;
    reg  [2:0] prescale;
    reg  [2:0] phase;
    wire       step_en;
    wire       carrier;

    assign chopper_enable    = chopper_control[`PCC_ENABLE_BIT];
    assign one_shot_width    = chopper_control[`PCC_WIDTH_LSB +: 4];
    assign chopper_frequency = chopper_control[`PCC_FREQ_LSB +: 3];
    assign chopper_duty      = chopper_control[`PCC_DUTY_LSB +: 3];

    // prescaler gives one step every (code+1) clocks
    assign step_en = (prescale >= chopper_frequency);

    // Eight phase steps make one carrier period
    always @(posedge clk) begin
        if (!rst_n) begin
            prescale <= 3'h0;
            phase    <= 3'h0;
        end else if (step_en) begin
            prescale <= 3'h0;
            phase    <= phase + 3'h1;
        end else begin
            prescale <= prescale + 3'h1;
        end
    end

    // high for (duty+1) of eight steps; 111 stays high
    assign carrier = (phase <= chopper_duty);

    // ------------------------------------------------------------
    // One-shot and chopped outputs, one lane per channel
    // ------------------------------------------------------------
    wire [1:0] lane_in;
    wire [1:0] lane_out;
    reg  [1:0] lane_prev;
    reg  [1:0] shot_on;
    reg  [6:0] shot_cnt [0:1];

    assign lane_in = {db_b, db_a};

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : lane
            wire rise;

            assign rise = lane_in[g] & ~lane_prev[g];

            // rise cycle plus 8*code+7 further clocks
            always @(posedge clk) begin
                if (!rst_n) begin
                    lane_prev[g] <= 1'b0;
                    shot_on[g]   <= 1'b0;
                    shot_cnt[g]  <= 7'h00;
                end else begin
                    lane_prev[g] <= lane_in[g];
                    if (rise) begin
                        shot_on[g]  <= 1'b1;
                        shot_cnt[g] <= {one_shot_width, 3'h6};
                    end else if (!lane_in[g] || shot_cnt[g] == 7'h00) begin
                        shot_on[g]  <= 1'b0;
                    end else begin
                        shot_cnt[g] <= shot_cnt[g] - 7'h01;
                    end
                end
            end

            assign lane_out[g] = lane_in[g] &
                                 (rise | shot_on[g] | carrier);
        end
    endgenerate

    // Registered outputs
    // enable bit selects chopped or plain signals
    always @(posedge clk) begin
        if (!rst_n) begin
            chop_a <= 1'b0;
            chop_b <= 1'b0;
        end else if (chopper_enable) begin
            chop_a <= lane_out[0];
            chop_b <= lane_out[1];
        end else begin
            chop_a <= db_a;
            chop_b <= db_b;
        end
    end

endmodule

`default_nettype wire

// ==== bench/pwm_source.sv ====
// Purpose: Upstream model that drives the two qualified PWM levels
// Assumes: Bench sets the wanted levels right after a clock edge
// Notes:   Time-base pulse held high, so delays count system clocks
`default_nettype none

module pwm_source (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic want_a,
    input  wire logic want_b,
    output var  logic chan_a,
    output var  logic chan_b,
    output wire logic tb_en
);
    timeunit 1ns;
    timeprecision 1ps;

    // One period per clock keeps long delay counts quick to run
    assign tb_en = 1'b1;

    // Levels leave a flop on clk, as a real qualifier stage does
    always @(posedge clk) begin
        if (!rst_n) begin
            chan_a <= 1'b0;
            chan_b <= 1'b0;
        end else begin
            chan_a <= want_a;
            chan_b <= want_b;
        end
    end
endmodule
`default_nettype wire

// ==== bench/stage_monitor.sv ====
// Purpose: Concurrent checks on the dead-band and chopper stage ports
// Assumes: Write address and data are taken at the same edge
// Notes:   Shadows output mode and chopper enable from bus writes
`default_nettype none

module stage_monitor (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [3:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        chan_a_in,
    input wire logic        chan_b_in,
    input wire logic        chop_a,
    input wire logic        chop_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        pend;
    logic        chop_on;
    logic        bypass;
    logic [1:0]  mode;
    logic [3:0]  wr_addr;
    logic [31:0] wr_data;

    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // -------------------------------------------------------------
    // Shadow of the two fields that pick the raw output path
    // -------------------------------------------------------------
    // Commits one edge after the handshake, when the stage loads it
    always @(posedge clk) begin
        if (!rst_n) begin
            pend    <= 1'b0;
            mode    <= 2'h0;
            chop_on <= 1'b0;
        end else begin
            pend <= s_axi_awvalid && s_axi_awready;
            if (pend && wr_addr == 4'h0)
                mode <= wr_data[1:0];
            if (pend && wr_addr == 4'hC)
                chop_on <= wr_data[0];
            if (s_axi_awvalid && s_axi_awready)
                wr_addr <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready)
                wr_data <= s_axi_wdata;
        end
    end
    assign bypass = (mode == 2'h0) && !chop_on;

    a_write_answer:
    // Response flag is loaded one edge after both halves are taken
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write answer late");
    a_aw_refused:
    assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address taken twice");
    a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
    a_read_clear:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data stays up");
    a_upper_zero:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
    a_bypass_a:
    assert property (bypass && $past(bypass) |-> chop_a == $past(chan_a_in))
    else $error("raw path A wrong");
    a_bypass_b:
    assert property (bypass && $past(bypass) |-> chop_b == $past(chan_b_in))
    else $error("raw path B wrong");
    a_one_shot_a:
    assert property (chop_on && mode == 2'h0 && $rose(chan_a_in) |=>
        (chop_a || !chan_a_in) [*8])
    else $error("first pulse cut short");

    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    cover property (chop_on && $rose(chop_a));
    cover property (mode == 2'h3 && $fell(chop_b));
endmodule

bind deadband_and_chopper_stage stage_monitor mon_u (
    .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .chan_a_in, .chan_b_in, .chop_a,
    .chop_b);
`default_nettype wire

// ==== bench/deadband_and_chopper_stage_bench.sv ====
// Purpose: Self-checking bench of the dead-band and chopper stage
// Assumes: Bus answers follow the designer's hand-over timing
// Notes:   Latency windows count the source model's flop as one
`default_nettype none

module deadband_and_chopper_stage_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst_n = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, want_a = 1'b0, want_b = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, tb_en;
    logic        chan_a_in, chan_b_in, chop_a, chop_b;
    int          error_cnt = 0;
    int          checks = 0;

    always #10 clk = ~clk;

    pwm_source src_u (.clk, .rst_n, .want_a, .want_b, .chan_a(chan_a_in),
                      .chan_b(chan_b_in), .tb_en);

    deadband_and_chopper_stage #(.DELAY_WIDTH(10)) dut_u (
        .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .tb_en, .chan_a_in, .chan_b_in,
        .chop_a, .chop_b);

    // -------------------------------------------------------------
    // Reporting and bus tasks
    // -------------------------------------------------------------
    task automatic close_out();
        $display("compared %0d mismatched %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chk_n(input string what, input int lo, input int hi,
                         input int seen);
        checks++;
        if (seen < lo || seen > hi) begin
            error_cnt++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi,
                     seen);
        end
    endtask

    // Both halves offered together; each dropped once it is taken
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d,
                             input logic [1:0] er);
        int n;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50 && !s_axi_bvalid; n++) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        if (n == 50)
            close_out_late();
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp,
                          input logic [1:0] er);
        int n;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50 && !s_axi_rvalid; n++) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        if (n == 50)
            close_out_late();
        s_axi_rready <= 1'b0;
        chk("rdata", exp, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask

    // A used-up wait limit counts as a mismatch and ends the run
    task automatic close_out_late();
        error_cnt++;
        $display("[ERR] wait expected answer seen none");
        close_out();
    endtask

    // Clocks until the chosen output shows the level, bounded
    task automatic time_to(input logic lane, input logic lvl,
                           output int n);
        for (n = 1; n < 1100; n++) begin
            @(posedge clk);
            if ((lane ? chop_b : chop_a) === lvl)
                break;
        end
        if (n == 1100)
            close_out_late();
    endtask

    // -------------------------------------------------------------
    // Test sequence
    // -------------------------------------------------------------
    initial begin
        int          n, c1, c2, cb, w;
        logic [1:0]  m, s, p;
        logic        ea, eb;
        logic [3:0]  ofs [4] = '{4'h0, 4'h4, 4'h8, 4'hC};
        logic [31:0] msk [4] = '{32'h3F, 32'h3FF, 32'h3FF, 32'h7FF};
        logic [3:0]  ws [3] = '{4'h0, 4'h2, 4'hF};
        logic [2:0]  fs [3] = '{3'h0, 3'h1, 3'h7};
        logic [2:0]  ds [3] = '{3'h0, 3'h3, 3'h6};
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd_chk(ofs[i], 32'h0, 2'h0);           // reset zero
            reg_write(ofs[i], 32'hFFFFFFFF, 2'h0);
            rd_chk(ofs[i], msk[i], 2'h0);
            reg_write(ofs[i], 32'h0, 2'h0);
        end
        reg_write(4'h2, 32'hFFFFFFFF, 2'h2);
        rd_chk(4'h2, 32'h0, 2'h2);
        $display("test registers done");
        want_a <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            m = (i < 16) ? i[1:0] : 2'h3;
            s = (i < 16) ? i[3:2] : 2'h0;
            p = (i >= 16) ? i[1:0] : (m == 2'h0) ? 2'h3 : 2'h0;
            reg_write(4'h0, {26'h0, s, p, m}, 2'h0);
            repeat (6) @(posedge clk);
            ea = m[1] ? (s[0] ? want_b : want_a) : want_a;
            eb = m[0] ? (s[1] ? want_b : want_a) : want_b;
            ea = ea ^ (m == 2'h3 && p[0]);
            eb = eb ^ (m == 2'h3 && p[1]);
            chk("chop_a", {31'h0, ea}, {31'h0, chop_a});
            chk("chop_b", {31'h0, eb}, {31'h0, chop_b});
        end
        $display("test routing done");
        reg_write(4'h0, 32'h3, 2'h0);
        for (int i = 0; i < 2; i++) begin
            reg_write(4'h4, i ? 32'h3FF : 32'h0, 2'h0);
            reg_write(4'h8, i ? 32'h3 : 32'h0, 2'h0);
            want_a <= 1'b0;
            repeat (8) @(posedge clk);
            want_a <= 1'b1;
            time_to(1'b0, 1'b1, n);
            chk_n("rise", i ? 1026 : 3, i ? 1027 : 4, n);
            repeat (8) @(posedge clk);
            want_a <= 1'b0;
            time_to(1'b1, 1'b0, n);
            chk_n("fall", i ? 6 : 3, i ? 7 : 4, n);       // count
        end
        $display("test delays done");
        reg_write(4'h0, 32'h0, 2'h0);
        for (int i = 0; i < 3; i++) begin
            want_a <= 1'b0;
            want_b <= 1'b0;
            reg_write(4'hC, {21'h0, ds[i], fs[i], ws[i], 1'b1}, 2'h0);
            repeat (4) @(posedge clk);
            want_a <= 1'b1;
            want_b <= 1'b1;
            time_to(1'b0, 1'b1, n);
            w = 8 * (ws[i] + 1);
            c1 = 0;
            c2 = 0;
            cb = 1;
            for (int k = 1; k < w + 16 * (fs[i] + 1); k++) begin
                @(posedge clk);
                c1 += (k < w && chop_a === 1'b1);
                c2 += (k >= w && chop_a === 1'b1);
                cb += (chop_b === 1'b1);
            end
            chk_n("shot", w - 1, w - 1, c1);
            n = 2 * (ds[i] + 1) * (fs[i] + 1);
            chk_n("carrier", n, n, c2);
            chk_n("lane b", w + n, w + n, cb);
        end
        reg_write(4'hC, 32'h0, 2'h0);
        repeat (4) @(posedge clk);
        chk("chop_a", {31'h0, want_a}, {31'h0, chop_a}); // bypass
        $display("test chopper done");
        close_out();
    end
endmodule
`default_nettype wire
